// ---- verilog/rrexec_defs.svh ----
// Constants for the return and rotate execution unit.
// Assumes inclusion by bare name from design files only.
`ifndef RREXEC_DEFS_SVH
`define RREXEC_DEFS_SVH
`define RREXEC_DATA_W        8
`define RREXEC_FADDR_W       7
`define RREXEC_PC_W          15
`define RREXEC_IRQ_EN_BIT    7
`define RREXEC_RET_CYCLES    2
`define RREXEC_ROT_CYCLES    1
`define RREXEC_RST_PULSE     4
`define RREXEC_DEST_W        1'b0
`define RREXEC_DEST_F        1'b1
`endif

// ---- verilog/rrexec_pkg.sv ----
// Types for the return and rotate execution unit.
// Assumes nothing beyond a SystemVerilog compiler.
package rrexec_pkg;
	typedef enum logic [2:0]
	{
		RREXEC_OP_NONE   = 3'b000,
		RREXEC_OP_SRST   = 3'b001,
		RREXEC_OP_IEXIT  = 3'b010,
		RREXEC_OP_SEXIT  = 3'b011,
		RREXEC_OP_LEXIT  = 3'b100,
		RREXEC_OP_ROTL   = 3'b101
	} rrexec_op_t;
	typedef enum logic [1:0]
	{
		RREXEC_ST_IDLE   = 2'b00,
		RREXEC_ST_RET2   = 2'b01,
		RREXEC_ST_RESET  = 2'b10
	} rrexec_state_t;
endpackage : rrexec_pkg

// ---- verilog/rrexec_rotl.sv ----
// Nine-bit rotate-left-through-carry datapath.
// Assumes operand and carry are stable within the cycle.
`timescale 1ns/100ps
`include "rrexec_defs.svh"
module rrexec_rotl #(
	parameter int DATA_W = `RREXEC_DATA_W
) (
	input  wire logic [DATA_W-1:0] operand,   // File register value
	input  wire logic              carry_in,  // Current carry
	output logic      [DATA_W-1:0] result,    // Rotated value
	output logic                   carry_out  // New carry
);
	// Refused at elaboration: a rotate needs at least two bits
	if (DATA_W < 2)
	begin : g_bad_data_w
		$error("rrexec_rotl: DATA_W too small");
	end
	always_comb
	begin
		result    = {operand[DATA_W-2:0], carry_in}; // RQ7 RQ10
		carry_out = operand[DATA_W-1];               // RQ10
	end
endmodule : rrexec_rotl

// ---- verilog/rrexec_core.sv ----
// Execution unit for software reset, the three returns and rotate left.
// Assumes the decoder presents one op per instruction cycle with
// OP_VALID and holds off new ops while BUSY is high.
`timescale 1ns/100ps
`include "rrexec_defs.svh"
// Summary of operation
// RQ1: Software reset instruction requests a full core reset like external reset.
// RQ2: Interrupt exit pops stack, loads top entry into PC, two cycles.
// RQ3: Interrupt exit sets global interrupt enable, bit 7 of control.
// RQ4: Subroutine exit pops stack, loads PC, flags untouched, two cycles.
// RQ5: Literal exit writes its 8-bit immediate into W, flags untouched.
// RQ6: Literal exit also loads PC from popped top entry, two cycles.
// RQ7: Rotate left moves file register one bit left through carry.
// RQ8: Destination bit 0 writes W, 1 writes file register back.
// RQ9: Rotate left changes only carry, one cycle, single word.
// RQ10: Old bit 7 becomes carry; old carry enters bit 0.
module rrexec_core #(
	parameter int DATA_W  = `RREXEC_DATA_W,
	parameter int FADDR_W = `RREXEC_FADDR_W,
	parameter int PC_W    = `RREXEC_PC_W
) (
	input  wire logic               REF_CLK,        // Core clock
	input  wire logic               RST_B,          // Async reset, low
	input  wire logic               OP_VALID,       // Op presented
	input  wire rrexec_pkg::rrexec_op_t OP_CODE,    // Decoded op
	input  wire logic [DATA_W-1:0]  OP_LITERAL,     // Immediate k
	input  wire logic [FADDR_W-1:0] OP_FADDR,       // File address f
	input  wire logic               OP_DEST,        // Destination d
	input  wire logic [DATA_W-1:0]  FILE_RDATA,     // Value at f
	input  wire logic [PC_W-1:0]    STACK_TOP,      // Top stack entry
	input  wire logic               CARRY_IN,       // Current carry
	input  wire logic [DATA_W-1:0]  IRQ_CTRL_IN,    // Control reg value
	output logic                    BUSY,           // Return second cycle, or soft reset held
	output logic                    STACK_POP,      // Pop strobe
	output logic                    PC_LOAD,        // PC write strobe
	output logic      [PC_W-1:0]    PC_DATA,        // New PC
	output logic                    W_WE,           // W write strobe
	output logic      [DATA_W-1:0]  W_DATA,         // New W
	output logic                    FILE_WE,        // File write strobe
	output logic      [FADDR_W-1:0] FILE_WADDR,     // File write address
	output logic      [DATA_W-1:0]  FILE_WDATA,     // File write data
	output logic                    CARRY_WE,       // Carry write strobe
	output logic                    CARRY_DATA,     // New carry
	output logic                    IRQ_CTRL_WE,    // Control write
	output logic      [DATA_W-1:0]  IRQ_CTRL_DATA,  // New control
	output logic                    SOFT_RESET_REQ  // Core reset request
);
	localparam int RST_CNT_W = 3;
	localparam logic [RST_CNT_W-1:0] RST_PULSE =
		RST_CNT_W'(`RREXEC_RST_PULSE - 1);

	// Refused at elaboration: the enable bit must fit in the word and
	// only the fixed two-cycle return and one-cycle rotate are built
	if (DATA_W <= `RREXEC_IRQ_EN_BIT)
	begin : g_bad_data_w
		$error("rrexec_core: DATA_W must hold enable bit");
	end
	if (`RREXEC_RET_CYCLES != 2 || `RREXEC_ROT_CYCLES != 1)
	begin : g_bad_cycles
		$error("rrexec_core: cycle counts not supported");
	end

	rrexec_pkg::rrexec_state_t state_reg, state_next;
	logic [RST_CNT_W-1:0] rcnt_reg, rcnt_next;
	logic                 pop_reg, pop_next;
	logic                 pcld_reg, pcld_next;
	logic [PC_W-1:0]      pc_reg, pc_next;
	logic                 wwe_reg, wwe_next;
	logic [DATA_W-1:0]    w_reg, w_next;
	logic                 fwe_reg, fwe_next;
	logic [FADDR_W-1:0]   fa_reg, fa_next;
	logic [DATA_W-1:0]    fd_reg, fd_next;
	logic                 cwe_reg, cwe_next;
	logic                 c_reg, c_next;
	logic                 iwe_reg, iwe_next;
	logic [DATA_W-1:0]    ic_reg, ic_next;
	logic [DATA_W-1:0]    rot_result;
	logic                 rot_carry;

	rrexec_rotl #(
		.DATA_W    (DATA_W)
	) u_rotl (
		.operand   (FILE_RDATA),
		.carry_in  (CARRY_IN),
		.result    (rot_result),
		.carry_out (rot_carry)
	);

	function automatic logic is_return(rrexec_pkg::rrexec_op_t op);
		return op == rrexec_pkg::RREXEC_OP_IEXIT ||
			op == rrexec_pkg::RREXEC_OP_SEXIT ||
			op == rrexec_pkg::RREXEC_OP_LEXIT;
	endfunction : is_return

	always_comb
	begin
		state_next = state_reg;
		rcnt_next  = rcnt_reg;
		pop_next   = 1'b0;
		pcld_next  = 1'b0;
		pc_next    = pc_reg;
		wwe_next   = 1'b0;
		w_next     = w_reg;
		fwe_next   = 1'b0;
		fa_next    = fa_reg;
		fd_next    = fd_reg;
		cwe_next   = 1'b0;
		c_next     = c_reg;
		iwe_next   = 1'b0;
		ic_next    = ic_reg;
		case (state_reg)
			rrexec_pkg::RREXEC_ST_IDLE:
			begin
				if (OP_VALID)
				begin
					// Pop and PC load are registered and show in the cycle after
					// the op is taken, the same cycle that BUSY is high.
					if (is_return(OP_CODE))
					begin
						pop_next   = 1'b1;      // RQ2 RQ4 RQ6
						pcld_next  = 1'b1;      // RQ2 RQ4 RQ6
						pc_next    = STACK_TOP; // RQ2 RQ4 RQ6
						state_next = rrexec_pkg::RREXEC_ST_RET2;
					end
					case (OP_CODE)
						rrexec_pkg::RREXEC_OP_SRST:
						begin
							rcnt_next  = RST_PULSE;
							state_next = rrexec_pkg::RREXEC_ST_RESET; // RQ1
						end
						rrexec_pkg::RREXEC_OP_IEXIT:
						begin
							iwe_next = 1'b1;
							ic_next  = IRQ_CTRL_IN;
							ic_next[`RREXEC_IRQ_EN_BIT] = 1'b1; // RQ3
						end
						rrexec_pkg::RREXEC_OP_LEXIT:
						begin
							wwe_next = 1'b1;       // RQ5
							w_next   = OP_LITERAL; // RQ5
						end
						rrexec_pkg::RREXEC_OP_ROTL:
						begin
							cwe_next = 1'b1;       // RQ9
							c_next   = rot_carry;  // RQ10
							if (OP_DEST == `RREXEC_DEST_W)
							begin
								wwe_next = 1'b1;   // RQ8
								w_next   = rot_result;
							end
							else
							begin
								fwe_next = 1'b1;   // RQ8
								fa_next  = OP_FADDR;
								fd_next  = rot_result;
							end
						end
						default:
						begin
						end
					endcase
				end
			end
			rrexec_pkg::RREXEC_ST_RET2:
				state_next = rrexec_pkg::RREXEC_ST_IDLE; // RQ2 RQ4 RQ6
			rrexec_pkg::RREXEC_ST_RESET:
			begin
				// Held until the core reset clears this block
				if (rcnt_reg != '0)
					rcnt_next = rcnt_reg - 1'b1;
			end
			default:
				state_next = rrexec_pkg::RREXEC_ST_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state_reg <= rrexec_pkg::RREXEC_ST_IDLE;
			rcnt_reg  <= '0;
			pop_reg   <= 1'b0;
			pcld_reg  <= 1'b0;
			pc_reg    <= '0;
			wwe_reg   <= 1'b0;
			w_reg     <= '0;
			fwe_reg   <= 1'b0;
			fa_reg    <= '0;
			fd_reg    <= '0;
			cwe_reg   <= 1'b0;
			c_reg     <= 1'b0;
			iwe_reg   <= 1'b0;
			ic_reg    <= '0;
		end
		else
		begin
			state_reg <= state_next;
			rcnt_reg  <= rcnt_next;
			pop_reg   <= pop_next;
			pcld_reg  <= pcld_next;
			pc_reg    <= pc_next;
			wwe_reg   <= wwe_next;
			w_reg     <= w_next;
			fwe_reg   <= fwe_next;
			fa_reg    <= fa_next;
			fd_reg    <= fd_next;
			cwe_reg   <= cwe_next;
			c_reg     <= c_next;
			iwe_reg   <= iwe_next;
			ic_reg    <= ic_next;
		end
	end

	assign BUSY           = state_reg != rrexec_pkg::RREXEC_ST_IDLE;
	assign SOFT_RESET_REQ = state_reg == rrexec_pkg::RREXEC_ST_RESET; // RQ1
	assign STACK_POP      = pop_reg;
	assign PC_LOAD        = pcld_reg;
	assign PC_DATA        = pc_reg;
	assign W_WE           = wwe_reg;
	assign W_DATA         = w_reg;
	assign FILE_WE        = fwe_reg;
	assign FILE_WADDR     = fa_reg;
	assign FILE_WDATA     = fd_reg;
	assign CARRY_WE       = cwe_reg;
	assign CARRY_DATA     = c_reg;
	assign IRQ_CTRL_WE    = iwe_reg;
	assign IRQ_CTRL_DATA  = ic_reg;
endmodule : rrexec_core

// ---- sim/rrexec_chk.sv ----
// Timing checks for the return and rotate unit.
// Assumes a bind onto rrexec_core from the bench top.
`timescale 1ns/100ps
module rrexec_chk #(
	parameter int DATA_W = 8,
	parameter int PC_W   = 15
) (
	input wire logic                   REF_CLK,        // Clock
	input wire logic                   RST_B,          // Reset
	input wire logic                   OP_VALID,       // Op valid
	input wire rrexec_pkg::rrexec_op_t OP_CODE,        // Op
	input wire logic [DATA_W-1:0]      OP_LITERAL,     // k
	input wire logic                   OP_DEST,        // d
	input wire logic [DATA_W-1:0]      FILE_RDATA,     // f value
	input wire logic [PC_W-1:0]        STACK_TOP,      // Top entry
	input wire logic                   CARRY_IN,       // Carry
	input wire logic                   BUSY,           // Busy
	input wire logic                   STACK_POP,      // Pop
	input wire logic                   PC_LOAD,        // PC load
	input wire logic [PC_W-1:0]        PC_DATA,        // New PC
	input wire logic                   W_WE,           // W write
	input wire logic [DATA_W-1:0]      W_DATA,         // New W
	input wire logic                   FILE_WE,        // f write
	input wire logic [DATA_W-1:0]      FILE_WDATA,     // New f
	input wire logic                   CARRY_WE,       // C write
	input wire logic                   CARRY_DATA,     // New C
	input wire logic                   IRQ_CTRL_WE,    // Ctrl write
	input wire logic [DATA_W-1:0]      IRQ_CTRL_DATA,  // New ctrl
	input wire logic                   SOFT_RESET_REQ  // Reset req
);
	logic tk, rt, ix, lx, ro, sr;
	assign tk = OP_VALID && !BUSY;
	assign ix = tk && OP_CODE == rrexec_pkg::RREXEC_OP_IEXIT;
	assign lx = tk && OP_CODE == rrexec_pkg::RREXEC_OP_LEXIT;
	assign ro = tk && OP_CODE == rrexec_pkg::RREXEC_OP_ROTL;
	assign sr = tk && OP_CODE == rrexec_pkg::RREXEC_OP_SRST;
	assign rt = ix || lx || tk && OP_CODE == rrexec_pkg::RREXEC_OP_SEXIT;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	// Second cycle of a return is a bubble, then free again
	sequence s_bubble;
		BUSY ##1 !BUSY;
	endsequence
	AST_POP: assert property (rt |=> STACK_POP && PC_LOAD
		&& PC_DATA == $past(STACK_TOP)) else $error("bad pop");
	AST_TWO: assert property (rt |=> s_bubble)
		else $error("return length wrong");
	AST_GIE: assert property (ix |=> IRQ_CTRL_WE && IRQ_CTRL_DATA[7])
		else $error("enable not set");
	AST_FLAGS: assert property (rt |=> !CARRY_WE)
		else $error("flag touched");
	AST_LIT: assert property (lx |=> W_WE
		&& W_DATA == $past(OP_LITERAL)) else $error("bad literal");
	AST_ROT: assert property (ro |=> CARRY_WE && !BUSY
		&& CARRY_DATA == $past(FILE_RDATA[DATA_W-1])) else $error("bad C");
	AST_ROTV: assert property (ro |=> (W_WE ? W_DATA : FILE_WDATA)
		== {$past(FILE_RDATA[DATA_W-2:0]), $past(CARRY_IN)})
		else $error("bad rotate");
	AST_DEST: assert property (ro |=> W_WE == !$past(OP_DEST)
		&& FILE_WE == $past(OP_DEST)) else $error("bad dest");
	AST_SRST: assert property (sr |=> (SOFT_RESET_REQ && BUSY)[*3])
		else $error("reset request lost");
endmodule : rrexec_chk

// ---- sim/tb_return_rotate_instr_exec.sv ----
// Self-checking bench for rrexec_core.
// Assumes the checker file is compiled before this one.
`timescale 1ns/100ps
module tb_return_rotate_instr_exec;
	logic REF_CLK = 1'b0, RST_B = 1'b0, OP_VALID = 1'b0;
	logic OP_DEST = 1'b0, CARRY_IN = 1'b0;
	rrexec_pkg::rrexec_op_t OP_CODE = rrexec_pkg::RREXEC_OP_NONE;
	logic [7:0]  OP_LITERAL = 8'h00, FILE_RDATA = 8'h00;
	logic [7:0]  IRQ_CTRL_IN = 8'h00, W_DATA, FILE_WDATA, IRQ_CTRL_DATA;
	logic [6:0]  OP_FADDR = 7'h00, FILE_WADDR;
	logic [14:0] STACK_TOP = 15'h0000, PC_DATA;
	logic BUSY, STACK_POP, PC_LOAD, W_WE, FILE_WE, CARRY_WE, CARRY_DATA;
	logic IRQ_CTRL_WE, SOFT_RESET_REQ;
	int err_count = 0, total_checks = 0, cyc = 0;
	rrexec_core u_dut (.REF_CLK, .RST_B, .OP_VALID, .OP_CODE, .OP_LITERAL,
		.OP_FADDR, .OP_DEST, .FILE_RDATA, .STACK_TOP, .CARRY_IN, .IRQ_CTRL_IN,
		.BUSY, .STACK_POP, .PC_LOAD, .PC_DATA, .W_WE, .W_DATA, .FILE_WE,
		.FILE_WADDR, .FILE_WDATA, .CARRY_WE, .CARRY_DATA, .IRQ_CTRL_WE,
		.IRQ_CTRL_DATA, .SOFT_RESET_REQ);
	always #2.5 REF_CLK = ~REF_CLK;
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict
	// Whole run needs about 20 cycles
	always @(posedge REF_CLK)
	begin
		cyc++;
		if (cyc == 500)
		begin
			err_count++;
			print_verdict();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Leaves OP_VALID high so callers can chain ops back to back
	task automatic issue(input rrexec_pkg::rrexec_op_t op,
		input logic [7:0] fr);
		OP_CODE = op;
		FILE_RDATA = fr;
		OP_VALID = 1'b1;
		@(posedge REF_CLK);
		#1;
	endtask : issue
	task automatic done(input string s);
		$display("test %s finished", s);
		@(posedge REF_CLK);
		#1;
	endtask : done
	task automatic t_rotl();
		logic [8:0] tab [3] = '{9'h0e6, 9'h101, 9'h180};
		OP_FADDR = 7'h7f;
		for (int i = 0; i < 3; i++)
		begin
			CARRY_IN = tab[i][8];
			OP_DEST = i[0];
			issue(rrexec_pkg::RREXEC_OP_ROTL, tab[i][7:0]);
			chk(i[0] ? FILE_WDATA : W_DATA, {tab[i][6:0], tab[i][8]});
			chk(CARRY_DATA, tab[i][7]);
			chk({CARRY_WE, BUSY, FILE_WE, W_WE}, {2'b10, i[0], !i[0]});
		end
		OP_VALID = 1'b0;
		chk(FILE_WADDR, 16'h007f);
		done("rotate");
	endtask : t_rotl
	task automatic t_ret();
		OP_LITERAL = 8'hff;
		IRQ_CTRL_IN = 8'h15;
		for (int i = 2; i < 5; i++)
		begin
			STACK_TOP = 15'h4000 | 15'(i);
			issue(rrexec_pkg::rrexec_op_t'(i), 8'h00);
			OP_CODE = rrexec_pkg::RREXEC_OP_ROTL;
			chk({STACK_POP, PC_LOAD, BUSY, CARRY_WE}, 16'he);
			chk(PC_DATA, STACK_TOP);
			chk({W_WE, IRQ_CTRL_WE}, {i == 4, i == 2});
			if (i == 4)
				chk(W_DATA, 16'h00ff);
			if (i == 2)
				chk(IRQ_CTRL_DATA, 16'h0095);
			@(posedge REF_CLK);
			#1;
			// The rotate offered while busy must have been dropped
			chk({BUSY, CARRY_WE, STACK_POP, W_WE}, 16'h0);
		end
		// A no-op must leave every strobe low
		issue(rrexec_pkg::RREXEC_OP_NONE, 8'hff);
		OP_VALID = 1'b0;
		chk({BUSY, STACK_POP, PC_LOAD, W_WE, FILE_WE, CARRY_WE}, 16'h0);
		chk({IRQ_CTRL_WE, SOFT_RESET_REQ}, 16'h0);
		done("returns");
	endtask : t_ret
	task automatic t_srst();
		issue(rrexec_pkg::RREXEC_OP_SRST, 8'h00);
		OP_VALID = 1'b0;
		repeat (3)
		begin
			chk({SOFT_RESET_REQ, BUSY}, 16'h3);
			@(posedge REF_CLK);
			#1;
		end
		RST_B = 1'b0;
		#1;
		chk(SOFT_RESET_REQ, 16'h0);
		@(posedge REF_CLK);
		#1;
		RST_B = 1'b1;
		done("soft reset");
	endtask : t_srst
	initial
	begin
		repeat (2) @(posedge REF_CLK);
		#1;
		RST_B = 1'b1;
		t_rotl();
		t_ret();
		t_srst();
		print_verdict();
	end
endmodule : tb_return_rotate_instr_exec
bind rrexec_core rrexec_chk #(.DATA_W(DATA_W), .PC_W(PC_W)) u_chk (.REF_CLK,
	.RST_B, .OP_VALID, .OP_CODE, .OP_LITERAL, .OP_DEST, .FILE_RDATA,
	.STACK_TOP, .CARRY_IN, .BUSY, .STACK_POP, .PC_LOAD, .PC_DATA, .W_WE,
	.W_DATA, .FILE_WE, .FILE_WDATA, .CARRY_WE, .CARRY_DATA, .IRQ_CTRL_WE,
	.IRQ_CTRL_DATA, .SOFT_RESET_REQ);
